// ---- verilog/pmmd_defines.svh ----
// Constants for the program memory map decoder.
// Included by the package users; holds no logic.
`ifndef PMMD_DEFINES_SVH
`define PMMD_DEFINES_SVH

`define PMMD_PC_W        21
`define PMMD_VEC_RESET   21'h000000
`define PMMD_VEC_HIGH    21'h000008
`define PMMD_VEC_LOW     21'h000018
`define PMMD_CFG_BASE_8K  21'h001FF8
`define PMMD_CFG_BASE_16K 21'h003FF8
`define PMMD_CFG_BASE_32K 21'h007FF8
`define PMMD_CFG_SPAN    21'h000008
`define PMMD_CFG_LAST    3'h7
`define PMMD_CFG_USED    3'h6
`define PMMD_CFG3L_IDX   3'h4
`define PMMD_MODE_MSB    5
`define PMMD_MODE_LSB    4
`define PMMD_SHIFT_BIT   3
`define PMMD_MODE_EXT20  2'h0
`define PMMD_MODE_EXT16  2'h1
`define PMMD_MODE_EXT12  2'h2
`define PMMD_MODE_ONCHIP 2'h3
`define PMMD_MASK20      20'hFFFFF
`define PMMD_MASK16      20'h0FFFF
`define PMMD_MASK12      20'h00FFF
`define PMMD_SP_MAX      5'h1F
`define PMMD_PC_STEP     21'h000002
`define PMMD_REG_STAT    8'h08
`define PMMD_REG_SP      8'h09
`define PMMD_REG_STACK_TOP_LOW    8'h0A
`define PMMD_REG_STACK_TOP_HIGH    8'h0B
`define PMMD_REG_STACK_TOP_UPPER    8'h0C
`define PMMD_REG_PCL     8'h0D
`define PMMD_REG_PCH     8'h0E
`define PMMD_REG_PCU     8'h0F

`endif

// ---- verilog/pmmd_pkg.sv ----
// Types shared by the program memory map decoder.
// Assumes pmmd_defines.svh supplies the numeric constants.
`default_nettype none
package pmmd_pkg;
   typedef enum logic [1:0] {PMMD_TGT_FLASH, PMMD_TGT_EXT, PMMD_TGT_ZERO} pmmd_target_t;
   typedef enum logic [1:0] {PMMD_ST_LOAD_REQ, PMMD_ST_LOAD_CAP, PMMD_ST_RUN} pmmd_state_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pmmd_reg_req_t;
   typedef struct packed {
      logic        rd;
      logic [19:0] addr;
   } pmmd_ext_req_t;
   typedef struct packed {
      logic wake;
      logic high;
      logic global_irq_enable_high;
      logic global_irq_enable_low;
   } pmmd_wake_t;
endpackage
`default_nettype wire

// ---- verilog/pmmd_decoder.sv ----
// Program memory map decoder: config load, address routing, PC, vectors.
// Assumes flash and external memory answer one cycle after a read strobe,
// and the core raises prog_req_i only while prog_ready_o is high.
//
// Overview of operation
// - Program counter is 21 bits wide over a 2 Mbyte byte space.
// - In on-chip-only mode, addresses above flash read as zero, a no-operation.
// - Every reset loads the program counter with address zero.
// - Fixed high and low priority interrupt entry addresses are supplied.
// - Last four flash words are reserved for configuration.
// - Each reset copies the first three reserved flash words into configuration registers.
// - Config bytes ascend: first word low byte lowest, fourth high highest.
// - Only the first three config words act; the fourth is ignored.
// - Config block starts at 1FF8h, 3FF8h or 7FF8h by flash size.
// - Memory mode comes from bits 5:4 of the third config low byte.
// - On-chip-only mode sends addresses below the top to flash and the rest to zero, never to external memory.
// - Small pin count parts are forced to on-chip-only mode.
// - Extended mode: flash below the top, external memory above it.
// - Fetches switch between memories automatically by address.
// - Memory mode also sets the external address width.
// - Data RAM access never depends on the memory mode.
// - Program and data memories use separate buses.
// - Interrupt wake with a global enable pushes the PC to stack top unless the pointer is at 1Fh.
// - That wake advances the return stack pointer, which holds at 1Fh.
// - That wake loads the PC with the high or low vector.
// - Mode codes: 00 20-bit, 01 16-bit, 10 12-bit, 11 on-chip only.
// - With shifting on, external address is program address minus flash size.
`include "pmmd_defines.svh"
`default_nettype none
module pmmd_decoder #(
   parameter int FLASH_KB  = 32,
   parameter bit SMALL_PKG = 1'b0
) (
   input  wire logic                     clk_i,
   input  wire logic                     reset_n_i,
   input  wire pmmd_pkg::pmmd_reg_req_t  reg_req_i,
   output logic [7:0]                    reg_rdata_o,
   input  wire logic                     prog_req_i,
   input  wire logic [20:0]              prog_addr_i,
   output logic                          prog_ready_o,
   output logic                          prog_valid_o,
   output logic [7:0]                    prog_data_o,
   output logic                          flash_rd_o,
   output logic [20:0]                   flash_addr_o,
   input  wire logic [7:0]               flash_data_i,
   output pmmd_pkg::pmmd_ext_req_t       ext_req_o,
   input  wire logic [7:0]               ext_data_i,
   input  wire logic                     pc_load_i,
   input  wire logic [20:0]              pc_load_addr_i,
   input  wire logic                     pc_inc_i,
   input  wire pmmd_pkg::pmmd_wake_t     wake_i,
   output logic [20:0]                   pc_o,
   output logic [4:0]                    return_stack_pointer_o,
   output logic [20:0]                   stack_top_o,
   output logic [15:0]                   first_config_word_o,
   output logic [15:0]                   second_config_word_o,
   output logic [15:0]                   third_config_word_o,
   output logic                          cfg_done_o
);
   import pmmd_pkg::*;

   // Config block base follows the flash size chosen at build time
   localparam logic [20:0] CFG_BASE = (FLASH_KB == 8)  ? `PMMD_CFG_BASE_8K  :
                                      (FLASH_KB == 16) ? `PMMD_CFG_BASE_16K :
                                                         `PMMD_CFG_BASE_32K;
   localparam logic [20:0] TOP = CFG_BASE + `PMMD_CFG_SPAN;

   logic        rst_meta_ff;
   logic        rst_n;
   pmmd_state_t state_ff;
   pmmd_state_t nxt_state;
   logic [2:0]  ld_idx_ff;
   logic [2:0]  nxt_ld_idx;
   logic [7:0]  cfg_ff [0:5];
   logic [20:0] pc_ff;
   logic [20:0] nxt_pc;
   logic [4:0]  return_stack_pointer_ff;
   logic [4:0]  nxt_sp;
   logic [20:0] stk_mem [1:31];
   pmmd_target_t acc_tgt_ff;
   logic        acc_vld_ff;
   logic [7:0]  prog_data_ff;
   logic        prog_vld_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;

   // Reset release through two flops; the rest of the block uses rst_n
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   // Config loader: one flash byte per request/capture pair, 16 cycles
   wire run      = (state_ff == PMMD_ST_RUN);
   wire ld_req   = (state_ff == PMMD_ST_LOAD_REQ);
   wire ld_cap   = (state_ff == PMMD_ST_LOAD_CAP);
   wire ld_last  = (ld_idx_ff == `PMMD_CFG_LAST);

   always_comb begin
      nxt_state  = state_ff;
      nxt_ld_idx = ld_idx_ff;
      case (state_ff)
         PMMD_ST_LOAD_REQ: nxt_state = PMMD_ST_LOAD_CAP;
         PMMD_ST_LOAD_CAP: begin
            // Fourth word is still walked so the sequence stays uniform
            if (ld_last) begin
               nxt_state = PMMD_ST_RUN;
            end else begin
               nxt_state  = PMMD_ST_LOAD_REQ;
               nxt_ld_idx = ld_idx_ff + 3'h1;
            end
         end
         PMMD_ST_RUN: nxt_state = PMMD_ST_RUN;
         default: nxt_state = PMMD_ST_LOAD_REQ;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_ff  <= PMMD_ST_LOAD_REQ;
         ld_idx_ff <= 3'h0;
      end else begin
         state_ff  <= nxt_state;
         ld_idx_ff <= nxt_ld_idx;
      end
   end

   // Byte i of the block sits at base + i; bytes 6 and 7 are dropped
   genvar gc;
   generate
      for (gc = 0; gc < 6; gc++) begin : g_cfg
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               cfg_ff[gc] <= 8'hFF;
            end else if (ld_cap && ld_idx_ff == 3'(gc)) begin
               cfg_ff[gc] <= flash_data_i;
            end
         end
      end
   endgenerate

   assign first_config_word_o  = {cfg_ff[1], cfg_ff[0]};
   assign second_config_word_o = {cfg_ff[3], cfg_ff[2]};
   assign third_config_word_o  = {cfg_ff[5], cfg_ff[4]};
   assign cfg_done_o           = run;

   // Config only changes during the load, so the mode holds until reset
   wire [7:0] third_config_low_byte  = cfg_ff[`PMMD_CFG3L_IDX];
   wire [1:0] memory_mode_select     = third_config_low_byte[`PMMD_MODE_MSB:`PMMD_MODE_LSB];
   wire       external_address_shift_enable = third_config_low_byte[`PMMD_SHIFT_BIT];
   wire       onchip_only_mode = SMALL_PKG || (memory_mode_select == `PMMD_MODE_ONCHIP);
   wire       extended_memory_mode = !onchip_only_mode;

   // External address width per mode
   wire [19:0] ext_mask = (memory_mode_select == `PMMD_MODE_EXT16) ? `PMMD_MASK16 :
                          (memory_mode_select == `PMMD_MODE_EXT12) ? `PMMD_MASK12 :
                                                                     `PMMD_MASK20;

   // Routing is combinational on every address, so crossing the top needs no software
   wire          below_top = (prog_addr_i < TOP);
   wire          take_req  = run && prog_req_i;
   wire pmmd_target_t tgt  = below_top         ? PMMD_TGT_FLASH :
                             onchip_only_mode  ? PMMD_TGT_ZERO  :
                                                 PMMD_TGT_EXT;
   wire [20:0]   shifted   = prog_addr_i - TOP;
   wire [20:0]   ext_raw   = external_address_shift_enable ? shifted : prog_addr_i;

   // Only the program bus is decoded here; the data RAM bus bypasses this block
   wire flash_hit = take_req && (tgt == PMMD_TGT_FLASH);
   wire ext_hit   = take_req && (tgt == PMMD_TGT_EXT) && extended_memory_mode;

   assign flash_rd_o     = ld_req || flash_hit;
   assign flash_addr_o   = ld_req ? (CFG_BASE + {18'h0, ld_idx_ff}) : prog_addr_i;
   assign ext_req_o.rd   = ext_hit;
   assign ext_req_o.addr = ext_hit ? (ext_raw[19:0] & ext_mask) : 20'h00000;
   assign prog_ready_o   = run;

   // Two-cycle read: memory answers, then the result is registered
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_tgt_ff <= PMMD_TGT_ZERO;
         acc_vld_ff <= 1'b0;
      end else begin
         acc_tgt_ff <= tgt;
         acc_vld_ff <= take_req;
      end
   end

   wire [7:0] mem_data = (acc_tgt_ff == PMMD_TGT_FLASH) ? flash_data_i :
                         (acc_tgt_ff == PMMD_TGT_EXT)   ? ext_data_i   :
                                                          8'h00;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prog_data_ff <= 8'h00;
         prog_vld_ff  <= 1'b0;
      end else begin
         prog_data_ff <= acc_vld_ff ? mem_data : 8'h00;
         prog_vld_ff  <= acc_vld_ff;
      end
   end

   assign prog_data_o  = prog_data_ff;
   assign prog_valid_o = prog_vld_ff;

   // Program counter; an interrupt wake outranks core loads and increments
   wire wake_ok  = run && wake_i.wake &&
                   (wake_i.global_irq_enable_high || wake_i.global_irq_enable_low);
   wire sp_full  = (return_stack_pointer_ff == `PMMD_SP_MAX);
   wire push_en  = wake_ok && !sp_full;
   wire [4:0] sp_up = return_stack_pointer_ff + 5'h01;

   assign nxt_pc = !run      ? pc_ff :
                   wake_ok   ? (wake_i.high ? `PMMD_VEC_HIGH : `PMMD_VEC_LOW) :
                   pc_load_i ? {pc_load_addr_i[20:1], 1'b0} :
                   pc_inc_i  ? pc_ff + `PMMD_PC_STEP :
                               pc_ff;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pc_ff <= `PMMD_VEC_RESET;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   assign pc_o = pc_ff;

   // Register decode
   wire wr     = reg_req_i.wr;
   wire sp_wr  = wr && (reg_req_i.addr == `PMMD_REG_SP);
   wire tl_wr  = wr && (reg_req_i.addr == `PMMD_REG_STACK_TOP_LOW);
   wire th_wr  = wr && (reg_req_i.addr == `PMMD_REG_STACK_TOP_HIGH);
   wire tu_wr  = wr && (reg_req_i.addr == `PMMD_REG_STACK_TOP_UPPER);

   // A push wins over a software pointer write in the same cycle
   assign nxt_sp = push_en ? sp_up :
                   sp_wr   ? reg_req_i.wdata[4:0] :
                             return_stack_pointer_ff;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         return_stack_pointer_ff <= 5'h00;
      end else begin
         return_stack_pointer_ff <= nxt_sp;
      end
   end

   genvar gs;
   generate
      for (gs = 1; gs < 32; gs++) begin : g_stk
         wire sel_push = push_en && (sp_up == 5'(gs));
         wire sel_sw   = (return_stack_pointer_ff == 5'(gs));
         always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
               stk_mem[gs] <= 21'h000000;
            end else if (sel_push) begin
               stk_mem[gs] <= pc_ff;
            end else if (sel_sw && tl_wr) begin
               stk_mem[gs][7:0] <= reg_req_i.wdata;
            end else if (sel_sw && th_wr) begin
               stk_mem[gs][15:8] <= reg_req_i.wdata;
            end else if (sel_sw && tu_wr) begin
               stk_mem[gs][20:16] <= reg_req_i.wdata[4:0];
            end
         end
      end
   endgenerate

   // Pointer zero has no storage behind it and reads as zero
   wire [20:0] tos = (return_stack_pointer_ff == 5'h00) ? 21'h000000 :
                     stk_mem[return_stack_pointer_ff];
   assign stack_top_o            = tos;
   assign return_stack_pointer_o = return_stack_pointer_ff;

   // Read mux; the fourth config word is not kept and reads as zero
   wire       cfg_rd_hit = (reg_req_i.addr[7:3] == 5'h00) && (reg_req_i.addr[2:0] < `PMMD_CFG_USED);
   wire [7:0] stat_byte  = {3'h0, external_address_shift_enable, memory_mode_select,
                            onchip_only_mode, run};
   assign nxt_rdata = !reg_req_i.rd                      ? 8'h00 :
                      cfg_rd_hit                         ? cfg_ff[reg_req_i.addr[2:0]] :
                      (reg_req_i.addr == `PMMD_REG_STAT) ? stat_byte :
                      (reg_req_i.addr == `PMMD_REG_SP)   ? {3'h0, return_stack_pointer_ff} :
                      (reg_req_i.addr == `PMMD_REG_STACK_TOP_LOW) ? tos[7:0] :
                      (reg_req_i.addr == `PMMD_REG_STACK_TOP_HIGH) ? tos[15:8] :
                      (reg_req_i.addr == `PMMD_REG_STACK_TOP_UPPER) ? {3'h0, tos[20:16]} :
                      (reg_req_i.addr == `PMMD_REG_PCL)  ? pc_ff[7:0] :
                      (reg_req_i.addr == `PMMD_REG_PCH)  ? pc_ff[15:8] :
                      (reg_req_i.addr == `PMMD_REG_PCU)  ? {3'h0, pc_ff[20:16]} :
                                                           8'h00;

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_o = rdata_ff;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   property p_pc_reset;
      !$past(rst_n) |-> pc_ff == `PMMD_VEC_RESET;
   endproperty
   a_pc_reset: assert property (p_pc_reset) else $error("PC not zero after reset");

   property p_vec_high;
      wake_ok && wake_i.high |=> pc_ff == `PMMD_VEC_HIGH;
   endproperty
   a_vec_high: assert property (p_vec_high) else $error("High vector not taken");

   property p_vec_low;
      wake_ok && !wake_i.high |=> pc_ff == `PMMD_VEC_LOW;
   endproperty
   a_vec_low: assert property (p_vec_low) else $error("Low vector not taken");

   property p_push_tos;
      push_en |=> (stack_top_o == $past(pc_ff)) && (return_stack_pointer_ff == $past(sp_up));
   endproperty
   a_push_tos: assert property (p_push_tos) else $error("Wake push lost");

   property p_sp_hold;
      !push_en && !sp_wr |=> $stable(return_stack_pointer_ff);
   endproperty
   a_sp_hold: assert property (p_sp_hold) else $error("Stack pointer moved unasked");

   property p_zero_fill;
      take_req && !below_top && onchip_only_mode |-> ##2 prog_valid_o && prog_data_o == 8'h00;
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("Unbacked address not zero");

   property p_no_ext;
      onchip_only_mode |-> !ext_req_o.rd;
   endproperty
   a_no_ext: assert property (p_no_ext) else $error("External access in on-chip mode");

   property p_ext_above;
      take_req && !below_top && extended_memory_mode |-> ext_req_o.rd && !flash_rd_o;
   endproperty
   a_ext_above: assert property (p_ext_above) else $error("High address not external");

   property p_flash_below;
      take_req && below_top |-> flash_rd_o && !ext_req_o.rd ##2 prog_data_o == $past(flash_data_i);
   endproperty
   a_flash_below: assert property (p_flash_below) else $error("Low address not flash");

   property p_shift;
      ext_req_o.rd && external_address_shift_enable |->
         ext_req_o.addr == ((prog_addr_i[19:0] - TOP[19:0]) & ext_mask);
   endproperty
   a_shift: assert property (p_shift) else $error("Shifted address wrong");

   property p_mode_stable;
      run |=> $stable(memory_mode_select) && run;
   endproperty
   a_mode_stable: assert property (p_mode_stable) else $error("Mode changed after load");

   property p_load_addr;
      ld_req |-> flash_addr_o == CFG_BASE + {18'h0, ld_idx_ff} ##1 ld_cap;
   endproperty
   a_load_addr: assert property (p_load_addr) else $error("Config read misplaced");

   c_wake_high: cover property (wake_ok && wake_i.high);
   c_ext_read:  cover property (ext_req_o.rd ##2 prog_valid_o);
   c_zero_read: cover property (take_req && tgt == PMMD_TGT_ZERO);
   c_cfg_done:  cover property ($rose(run));

endmodule // pmmd_decoder
`default_nettype wire

// ---- verilog/pmmd_pc_note.sv ----
`default_nettype none
`default_nettype wire

// ---- test/pmmd_mem_model.sv ----
// Behavioural on-chip flash and external program memory for the decoder.
// Assumes one-cycle reads; idle data lines toggle so a stale byte never matches.
`default_nettype none
module pmmd_mem_model (
   input  wire logic                    clk_i,
   input  wire logic                    flash_rd_i,
   input  wire logic [20:0]             flash_addr_i,
   output logic [7:0]                   flash_data_o,
   input  wire pmmd_pkg::pmmd_ext_req_t ext_req_i,
   output logic [7:0]                   ext_data_o,
   input  wire logic [7:0]              mode_byte_i
);
   timeunit 1ns;
   timeprecision 1ps;
   import pmmd_pkg::*;

   function automatic logic [7:0] flash_byte(input logic [20:0] a);
      logic [63:0] cfg;
      cfg = {8'hDE, 8'hBC, 8'h9A, mode_byte_i, 8'h78, 8'h56, 8'h34, 8'h12};
      if (a[20:3] == 18'h00FFF) return cfg[a[2:0] * 8 +: 8];
      return a[7:0] ^ a[15:8];
   endfunction

   always @(posedge clk_i) begin
      flash_data_o <= flash_rd_i ? flash_byte(flash_addr_i) : ~flash_data_o;
      ext_data_o   <= ext_req_i.rd ? (ext_req_i.addr[7:0] ^ 8'hA5) : ~ext_data_o;
   end
endmodule // pmmd_mem_model
`default_nettype wire

// ---- test/pmmd_decoder_bench.sv ----
// Self-checking bench for the program memory map decoder, 32 Kbyte build.
// Assumes pmmd_mem_model stands in for flash and external memory.
`include "pmmd_defines.svh"
`default_nettype none
module pmmd_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmmd_pkg::*;

   logic           clk_i = 1'b0;
   logic           reset_n_i = 1'b0;
   pmmd_reg_req_t  reg_req = '0;
   logic [7:0]     reg_rdata, prog_data, flash_data, ext_data, mode_byte = 8'h30;
   logic           prog_req = 1'b0, pc_load = 1'b0, pc_inc = 1'b0;
   logic [20:0]    prog_addr = '0, pc_load_addr = '0, flash_addr, pc, tos;
   logic           prog_ready, prog_valid, flash_rd, cfg_done, prog_valid2;
   logic [7:0]     prog_data2;
   pmmd_ext_req_t  ext_req, ext_req2;
   pmmd_wake_t     wake = '0;
   logic [4:0]     sp;
   logic [15:0]    cw1, cw2, cw3;
   int             n_errors = 0;
   int             num_checks = 0;
   logic [7:0]     modes [5] = '{8'h30, 8'h00, 8'h10, 8'h20, 8'h08};

   always #25 clk_i = ~clk_i;

   pmmd_decoder #(.FLASH_KB(32), .SMALL_PKG(1'b0)) DUT (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req), .reg_rdata_o(reg_rdata),
      .prog_req_i(prog_req), .prog_addr_i(prog_addr), .prog_ready_o(prog_ready),
      .prog_valid_o(prog_valid), .prog_data_o(prog_data), .flash_rd_o(flash_rd),
      .flash_addr_o(flash_addr), .flash_data_i(flash_data), .ext_req_o(ext_req),
      .ext_data_i(ext_data), .pc_load_i(pc_load), .pc_load_addr_i(pc_load_addr),
      .pc_inc_i(pc_inc), .wake_i(wake), .pc_o(pc), .return_stack_pointer_o(sp),
      .stack_top_o(tos), .first_config_word_o(cw1), .second_config_word_o(cw2),
      .third_config_word_o(cw3), .cfg_done_o(cfg_done));

   // Small package build on the same stimulus; shares the memories since it never reads above the top
   pmmd_decoder #(.FLASH_KB(32), .SMALL_PKG(1'b1)) dut_small (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req), .reg_rdata_o(),
      .prog_req_i(prog_req), .prog_addr_i(prog_addr), .prog_ready_o(),
      .prog_valid_o(prog_valid2), .prog_data_o(prog_data2), .flash_rd_o(),
      .flash_addr_o(), .flash_data_i(flash_data), .ext_req_o(ext_req2),
      .ext_data_i(ext_data), .pc_load_i(pc_load), .pc_load_addr_i(pc_load_addr),
      .pc_inc_i(pc_inc), .wake_i(wake), .pc_o(), .return_stack_pointer_o(),
      .stack_top_o(), .first_config_word_o(), .second_config_word_o(),
      .third_config_word_o(), .cfg_done_o());

   pmmd_mem_model mem (
      .clk_i(clk_i), .flash_rd_i(flash_rd), .flash_addr_i(flash_addr), .flash_data_o(flash_data),
      .ext_req_i(ext_req), .ext_data_o(ext_data), .mode_byte_i(mode_byte));

   task automatic close_out();
      $display("checks %0d, mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [20:0] got, input logic [20:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      reg_req <= '0;
      #1 check(reg_rdata, exp);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      reg_req <= '0;
   endtask

   // Target code: 0 flash, 1 external, 2 zero region
   task automatic fetch(input logic [20:0] a, input logic [1:0] tgt, input logic [19:0] ea,
                        input logic [7:0] exp);
      @(posedge clk_i);
      prog_req  <= 1'b1;
      prog_addr <= a;
      #1 check(flash_rd, tgt == 2'd0);
      check(ext_req.rd, tgt == 2'd1);
      check(ext_req2.rd, 1'b0);
      if (tgt == 2'd0)
         check(flash_addr, a);
      if (tgt == 2'd1)
         check(ext_req.addr, ea);
      @(posedge clk_i);
      prog_req <= 1'b0;
      @(posedge clk_i);
      #1 check(prog_valid, 1'b1);
      check(prog_data, exp);
      check(prog_valid2, 1'b1);
      check(prog_data2, (tgt == 2'd0) ? exp : 8'h00);
   endtask

   task automatic pc_op(input logic ld, input logic inc, input logic [20:0] a);
      @(posedge clk_i);
      pc_load      <= ld;
      pc_inc       <= inc;
      pc_load_addr <= a;
      @(posedge clk_i);
      pc_load <= 1'b0;
      pc_inc  <= 1'b0;
      #1;
   endtask

   // Fields: wake, high, enable high, enable low
   task automatic pulse_wake(input logic [3:0] w);
      @(posedge clk_i);
      wake <= w;
      @(posedge clk_i);
      wake <= '0;
      #1;
   endtask

   task automatic do_reset(input logic [7:0] mb);
      int n;
      @(posedge clk_i);
      mode_byte <= mb;
      reset_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      #1 check(prog_ready, 1'b0);
      n = 0;
      while (cfg_done !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 40) begin
         n_errors++;
         close_out();
      end
      #1;
   endtask

   initial begin
      logic [7:0]  mb;
      logic [20:0] sh_a;
      logic [19:0] ea;
      logic        onchip;
      for (int i = 0; i < 5; i++) begin
         mb = modes[i];
         do_reset(mb);
         check(pc, `PMMD_VEC_RESET);
         reg_rd(8'h0D, 8'h00);
         check(cw1, 16'h3412);
         check(cw2, 16'h7856);
         check(cw3, {8'h9A, mb});
         reg_rd(8'h06, 8'h00);
         reg_rd(8'h04, mb);
         reg_rd(8'h08, {3'b000, mb[3], mb[5:4], mb[5:4] == 2'b11, 1'b1});
         onchip = (mb[5:4] == 2'b11);
         sh_a = mb[3] ? 21'h1ABCDE - 21'h008000 : 21'h1ABCDE;
         ea = sh_a[19:0] & (mb[5:4] == 2'b00 ? 20'hFFFFF : mb[5:4] == 2'b01 ? 20'h0FFFF : 20'h00FFF);
         fetch(21'h007FFF, 2'd0, 20'h00000, 8'hDE);
         fetch(21'h1ABCDE, onchip ? 2'd2 : 2'd1, ea, onchip ? 8'h00 : 8'h7B);
         pc_op(1'b1, 1'b0, 21'h001234);
      end
      reg_rd(8'h40, 8'h00);
      reg_wr(8'h0D, 8'hFF);
      reg_rd(8'h0D, 8'h34);
      pc_op(1'b1, 1'b0, 21'h1F1235);
      pc_op(1'b0, 1'b1, 21'h000000);
      check(pc, 21'h1F1236);
      pulse_wake(4'b1100);
      check(pc, 21'h1F1236);
      pulse_wake(4'b1110);
      check(pc, `PMMD_VEC_HIGH);
      check(sp, 5'h01);
      check(tos, 21'h1F1236);
      reg_rd(8'h0C, 8'h1F);
      pulse_wake(4'b1001);
      check(pc, `PMMD_VEC_LOW);
      check(sp, 5'h02);
      check(tos, 21'h000008);
      reg_wr(8'h09, 8'h1F);
      pulse_wake(4'b1110);
      check(pc, `PMMD_VEC_HIGH);
      check(sp, 5'h1F);
      reg_rd(8'h09, 8'h1F);
      close_out();
   end
endmodule // pmmd_decoder_bench
`default_nettype wire
